// ### npps_pkg.sv
/*
 * npps_pkg: shared constants for the nco preset and phase sync block.
 * Assumes byte addresses of 12 bits and a 32-bit register data path.
 */
package npps_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int ADDR_W   = 12;
   localparam int DATA_W   = 32;
   localparam int FREQ_W   = 32;
   localparam int PHASE_W  = 16;
   localparam int N_CH     = 2;
   localparam int N_PRESET = 4;
   localparam int SEL_W    = 2;
   localparam int ALIGN_W  = 8;
   localparam int RDIV_W   = 16;
   localparam int CTRL_W   = 5;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_PRESET_SEL = 12'h215;
   localparam logic [ADDR_W-1:0] OFS_RDIV       = 12'h217;
   localparam logic [ADDR_W-1:0] OFS_ALIGN      = 12'h219;
   localparam logic [ADDR_W-1:0] OFS_FREQ_A0    = 12'h220;
   localparam logic [ADDR_W-1:0] OFS_PHASE_A0   = 12'h224;
   localparam logic [ADDR_W-1:0] OFS_PRESET_END = 12'h25F;

   // ----------------------------------------------------------------
   // field positions inside the preset window and the control words
   // ----------------------------------------------------------------
   localparam int PRE_CH_BIT    = 5;
   localparam int PRE_IDX_LSB   = 3;
   localparam int PRE_PHASE_BIT = 2;
   localparam int ALIGN_ARM_BIT = 0;
   localparam int ALIGN_ILA_BIT = 1;
   localparam int SEL_B_LSB     = 2;
   localparam int SEL_SRC_BIT   = 4;

   // ----------------------------------------------------------------
   // values after reset
   // ----------------------------------------------------------------
   localparam logic [FREQ_W-1:0]  FREQ_RST  = 32'hC0000000;
   localparam logic [PHASE_W-1:0] PHASE_RST = 16'h0000;
   localparam logic [RDIV_W-1:0]  RDIV_RST  = 16'h0000;
   localparam logic [ALIGN_W-1:0] ALIGN_RST = 8'h02;
   localparam logic [CTRL_W-1:0]  SEL_RST   = 5'h00;

   // ----------------------------------------------------------------
   // controller timing, in clk cycles
   // ----------------------------------------------------------------
   localparam logic [7:0] SYSREF_HIGH_CYC = 8'h04;
   localparam logic [7:0] SYSREF_LOW_CYC  = 8'h10;

endpackage : npps_pkg

// ### npps_if.sv
/*
 * npps_if: link between the converter end and its controlling party.
 * Assumes both ends share clk; every signal is a plain level per cycle.
 */
`timescale 1ns/1ps
`default_nettype none

interface npps_if;
   logic                         sync_n;
   logic                         sysref;
   logic                         reg_wr;
   logic                         reg_rd;
   logic [npps_pkg::ADDR_W-1:0]  reg_addr;
   logic [npps_pkg::DATA_W-1:0]  reg_wdata;
   logic [npps_pkg::DATA_W-1:0]  reg_rdata;
   logic                         reg_rvalid;

   modport dev (
      input  sync_n,
      input  sysref,
      input  reg_wr,
      input  reg_rd,
      input  reg_addr,
      input  reg_wdata,
      output reg_rdata,
      output reg_rvalid
   );

   modport ctl (
      output sync_n,
      output sysref,
      output reg_wr,
      output reg_rd,
      output reg_addr,
      output reg_wdata,
      input  reg_rdata,
      input  reg_rvalid
   );
endinterface : npps_if

`default_nettype wire

// ### npps_acc.sv
/*
 * npps_acc: one phase accumulator with phase offset, one per channel.
 * Assumes init and advance come from the same clk domain.
 */
`timescale 1ns/1ps
`default_nettype none

module npps_acc #(
   parameter int FW = 32,
   parameter int PW = 16
) (
   input  wire logic          clk,
   input  wire logic          arst_n,
   input  wire logic          advance,
   input  wire logic          init,
   input  wire logic [FW-1:0] freq_word,
   input  wire logic [PW-1:0] phase_word,
   output logic      [FW-1:0] phase_out
);

   typedef struct packed {
      logic [FW-1:0] acc;
      logic [FW-1:0] out;
   } npps_acc_state_t;

   npps_acc_state_t s_q;
   npps_acc_state_t s_d;

   // ----------------------------------------------------------------
   // accumulate
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      if (init) begin
         s_d.acc = '0;                                   // see (RULE18)
      end else if (advance) begin
         // modulo add, so signed and unsigned words behave alike
         s_d.acc = s_q.acc + freq_word;                  // see (RULE7) see (RULE8) see (RULE18)
      end
      s_d.out = s_d.acc + {phase_word, {(FW-PW){1'b0}}}; // see (RULE14) see (RULE15)
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign phase_out = s_q.out;

endmodule : npps_acc

`default_nettype wire

// ### npps_dev.sv
/*
 * npps_dev: converter end; preset registers, phase accumulators and
 * the two phase alignment paths (link start and armed sysref).
 * Assumes lmfc_boundary is a one-cycle pulse from the local link
 * framer, and sample_valid marks each converter sample on clk.
 */
// What this block does
// (RULE1) link-start alignment reinitialises phase at next boundary
// (RULE2) link-start alignment works in both encodings
// (RULE3) wide encoding: sync only aligns, link unaffected
// (RULE4) arm by writing zero then one; sysref aligns
// (RULE5) later sysref edges ignored until rearmed
// (RULE6) controller order: ready, quiet, clear, arm, pulse
// (RULE7) frequency word is 32-bit accumulator step
// (RULE8) signed or unsigned word gives same behaviour
// (RULE9) software computes word from wanted frequency
// (RULE10) non-integer word: use step and divisor
// (RULE11) frequency change needs fresh alignment afterwards
// (RULE12) four presets per channel, common encoding
// (RULE13) frequency presets reset to C0000000
// (RULE14) phase offset left justified, added to accumulator
// (RULE15) phase offset scales by two pi over 65536
// (RULE16) two-bit selector picks preset; single uses A
// (RULE17) zero divisor means plain 32-bit accumulator
// (RULE18) accumulator adds per sample, init loads zero
`timescale 1ns/1ps
`default_nettype none

module npps_dev (
   input  wire logic                          clk,
   input  wire logic                          arst_n,
   npps_if.dev                                lnk,
   input  wire logic                          link_mode_64b66b,
   input  wire logic                          single_channel_mode,
   input  wire logic                          lmfc_boundary,
   input  wire logic                          sample_valid,
   input  wire logic [npps_pkg::SEL_W-1:0]    preset_pin_sel_a,
   input  wire logic [npps_pkg::SEL_W-1:0]    preset_pin_sel_b,
   output logic                               link_sync_n,
   output logic                               phase_init_pulse,
   output logic                               sync_armed,
   output logic                               fractional_mode,
   output logic [npps_pkg::FREQ_W-1:0]        nco_phase_a,
   output logic [npps_pkg::FREQ_W-1:0]        nco_phase_b
);

   typedef struct packed {
      logic [npps_pkg::N_CH-1:0][npps_pkg::N_PRESET-1:0][npps_pkg::FREQ_W-1:0]  freq;
      logic [npps_pkg::N_CH-1:0][npps_pkg::N_PRESET-1:0][npps_pkg::PHASE_W-1:0] phase;
      logic [npps_pkg::RDIV_W-1:0]  rdiv;
      logic [npps_pkg::CTRL_W-1:0]  sel;
      logic [npps_pkg::ALIGN_W-1:0] align;
      logic                         zero_seen;
      logic                         armed;
      logic                         sync_prev;
      logic                         sysref_prev;
      logic                         pend;
      logic                         init;
      logic [npps_pkg::DATA_W-1:0]  rdata;
      logic                         rvalid;
   } npps_dev_state_t;

   localparam npps_dev_state_t DEV_RST = '{
      freq:        {(npps_pkg::N_CH*npps_pkg::N_PRESET){npps_pkg::FREQ_RST}},
      phase:       {(npps_pkg::N_CH*npps_pkg::N_PRESET){npps_pkg::PHASE_RST}},
      rdiv:        npps_pkg::RDIV_RST,
      sel:         npps_pkg::SEL_RST,
      align:       npps_pkg::ALIGN_RST,
      zero_seen:   1'b0,
      armed:       1'b0,
      sync_prev:   1'b1,
      sysref_prev: 1'b1,
      pend:        1'b0,
      init:        1'b0,
      rdata:       '0,
      rvalid:      1'b0
   };

   npps_dev_state_t s_q;
   npps_dev_state_t s_d;

   logic                         in_preset;
   logic [5:0]                   pre_idx;
   logic                         pre_ch;
   logic [npps_pkg::SEL_W-1:0]   pre_num;
   logic                         pre_is_phase;
   logic [npps_pkg::DATA_W-1:0]  rd_word;
   logic                         sync_rise;
   logic                         sysref_rise;
   logic                         ila_trig;
   logic                         sysref_trig;
   logic                         init_now;
   logic [npps_pkg::SEL_W-1:0]   sel_act [npps_pkg::N_CH];
   logic [npps_pkg::FREQ_W-1:0]  phase_out [npps_pkg::N_CH];

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   // eight presets at 8-byte stride, frequency then phase word
   assign pre_idx      = 6'(lnk.reg_addr - npps_pkg::OFS_FREQ_A0);
   assign in_preset    = (lnk.reg_addr >= npps_pkg::OFS_FREQ_A0)
                         && (lnk.reg_addr <= npps_pkg::OFS_PRESET_END)
                         && (lnk.reg_addr[1:0] == 2'h0);            // see (RULE12)
   assign pre_ch       = pre_idx[npps_pkg::PRE_CH_BIT];
   assign pre_num      = pre_idx[npps_pkg::PRE_IDX_LSB +: npps_pkg::SEL_W];
   assign pre_is_phase = pre_idx[npps_pkg::PRE_PHASE_BIT];

   always_comb begin
      rd_word = '0;
      if (in_preset) begin
         if (pre_is_phase) begin
            rd_word = {16'h0000, s_q.phase[pre_ch][pre_num]};
         end else begin
            rd_word = s_q.freq[pre_ch][pre_num];
         end
      end else begin
         case (lnk.reg_addr)
            npps_pkg::OFS_PRESET_SEL: rd_word = {27'h0000000, s_q.sel};
            npps_pkg::OFS_RDIV:       rd_word = {16'h0000, s_q.rdiv};
            npps_pkg::OFS_ALIGN:      rd_word = {24'h000000, s_q.align};
            default:                  rd_word = '0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // alignment triggers
   // ----------------------------------------------------------------
   assign sync_rise   = lnk.sync_n & ~s_q.sync_prev;
   assign sysref_rise = lnk.sysref & ~s_q.sysref_prev;
   // a boundary in the same cycle as the rise is not "after" it
   assign ila_trig    = s_q.pend & lmfc_boundary & lnk.sync_n
                        & s_q.align[npps_pkg::ALIGN_ILA_BIT];      // see (RULE1) see (RULE2)
   assign sysref_trig = sysref_rise & s_q.armed;                   // see (RULE4) see (RULE5)
   assign init_now    = ila_trig | sysref_trig;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d             = s_q;
      s_d.rvalid      = 1'b0;
      s_d.sync_prev   = lnk.sync_n;
      s_d.sysref_prev = lnk.sysref;
      s_d.init        = init_now;

      if (sync_rise) begin
         s_d.pend = 1'b1;
      end else if (lmfc_boundary || !lnk.sync_n) begin
         s_d.pend = 1'b0;
      end

      // one sysref use per arming
      if (sysref_trig) begin
         s_d.armed = 1'b0;                                          // see (RULE5)
      end

      if (lnk.reg_wr) begin
         if (in_preset) begin
            if (pre_is_phase) begin
               s_d.phase[pre_ch][pre_num] = lnk.reg_wdata[npps_pkg::PHASE_W-1:0];
            end else begin
               // no automatic realignment; the controller must resync
               s_d.freq[pre_ch][pre_num] = lnk.reg_wdata;           // see (RULE11)
            end
         end else begin
            case (lnk.reg_addr)
               npps_pkg::OFS_PRESET_SEL: begin
                  s_d.sel = lnk.reg_wdata[npps_pkg::CTRL_W-1:0];
               end
               npps_pkg::OFS_RDIV: begin
                  s_d.rdiv = lnk.reg_wdata[npps_pkg::RDIV_W-1:0];
               end
               npps_pkg::OFS_ALIGN: begin
                  s_d.align = lnk.reg_wdata[npps_pkg::ALIGN_W-1:0];
                  // arming needs a zero write followed by a one write
                  if (!lnk.reg_wdata[npps_pkg::ALIGN_ARM_BIT]) begin
                     s_d.zero_seen = 1'b1;                          // see (RULE4)
                  end else if (s_q.zero_seen) begin
                     s_d.zero_seen = 1'b0;
                     s_d.armed     = 1'b1;                          // see (RULE4)
                  end
               end
               default: begin
               end
            endcase
         end
      end

      if (lnk.reg_rd) begin
         s_d.rvalid = 1'b1;
         s_d.rdata  = rd_word;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= DEV_RST;                                            // see (RULE13)
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // preset selection and accumulators
   // ----------------------------------------------------------------
   always_comb begin
      if (s_q.sel[npps_pkg::SEL_SRC_BIT]) begin
         sel_act[0] = preset_pin_sel_a;
         sel_act[1] = preset_pin_sel_b;
      end else begin
         sel_act[0] = s_q.sel[npps_pkg::SEL_W-1:0];                 // see (RULE16)
         sel_act[1] = s_q.sel[npps_pkg::SEL_B_LSB +: npps_pkg::SEL_W];
      end
   end

   for (genvar c = 0; c < npps_pkg::N_CH; c++) begin : g_ch
      // single channel mode: channel B mirrors channel A and its selector
      localparam int BANK_B = c;
      logic                          bank;
      logic [npps_pkg::SEL_W-1:0]    sel_c;
      assign bank  = single_channel_mode ? 1'b0 : 1'(BANK_B);      // see (RULE16)
      assign sel_c = single_channel_mode ? sel_act[0] : sel_act[c];

      // divisor of zero keeps the plain wrap; a nonzero one is
      // reported only, its modulus trim lives outside this block
      npps_acc #(
         .FW (npps_pkg::FREQ_W),
         .PW (npps_pkg::PHASE_W)
      ) u_acc (
         .clk        (clk),
         .arst_n     (arst_n),
         .advance    (sample_valid),
         .init       (init_now),
         .freq_word  (s_q.freq[bank][sel_c]),                       // see (RULE17) see (RULE18)
         .phase_word (s_q.phase[bank][sel_c]),
         .phase_out  (phase_out[c])
      );
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // in the wide encoding the link never sees sync
   assign link_sync_n      = link_mode_64b66b ? 1'b1 : lnk.sync_n;  // see (RULE3)
   assign phase_init_pulse = s_q.init;
   assign sync_armed       = s_q.armed;
   assign fractional_mode  = |s_q.rdiv;                              // see (RULE17)
   assign nco_phase_a      = phase_out[0];
   assign nco_phase_b      = phase_out[1];
   assign lnk.reg_rdata    = s_q.rdata;
   assign lnk.reg_rvalid   = s_q.rvalid;

endmodule : npps_dev

`default_nettype wire

// ### npps_ctl.sv
/*
 * npps_ctl: controlling party; register access, sync level from the
 * link receiver, and the multi-part alignment sequence with sysref.
 * Assumes the user keeps cmd_valid until cmd_ready.
 */
`timescale 1ns/1ps
`default_nettype none

module npps_ctl (
   input  wire logic                          clk,
   input  wire logic                          arst_n,
   npps_if.ctl                                lnk,
   input  wire logic                          cmd_valid,
   output logic                               cmd_ready,
   input  wire logic                          cmd_write,
   input  wire logic [npps_pkg::ADDR_W-1:0]   cmd_addr,
   input  wire logic [npps_pkg::DATA_W-1:0]   cmd_wdata,
   output logic                               rsp_valid,
   output logic [npps_pkg::DATA_W-1:0]        rsp_rdata,
   input  wire logic                          rx_sync_request,
   input  wire logic                          device_ready,
   input  wire logic                          align_start,
   input  wire logic [3:0]                    align_pulses,
   input  wire logic                          resync_on_freq_write,
   output logic                               align_busy
);

   typedef enum logic [2:0] {
      C_IDLE,
      C_WAIT_RDY,
      C_CLR,
      C_ARM,
      C_PULSE_LO,
      C_PULSE_HI
   } npps_ctl_st_t;

   typedef struct packed {
      npps_ctl_st_t                 st;
      logic                         wr;
      logic                         rd;
      logic [npps_pkg::ADDR_W-1:0]  addr;
      logic [npps_pkg::DATA_W-1:0]  wdata;
      logic                         sync_n;
      logic                         sysref;
      logic [7:0]                   cnt;
      logic [3:0]                   pulses;
      logic                         resync;
   } npps_ctl_state_t;

   npps_ctl_state_t s_q;
   npps_ctl_state_t s_d;
   logic            freq_hit;

   assign freq_hit = (cmd_addr >= npps_pkg::OFS_FREQ_A0)
                     && (cmd_addr <= npps_pkg::OFS_PRESET_END)
                     && (cmd_addr[2] == 1'b0);

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_comb begin
      s_d        = s_q;
      s_d.wr     = 1'b0;
      s_d.rd     = 1'b0;
      s_d.sync_n = ~rx_sync_request;
      case (s_q.st)
         C_IDLE: begin
            if (cmd_valid) begin
               // words pass as computed by software, unaltered
               s_d.wr    = cmd_write;                               // see (RULE9) see (RULE10)
               s_d.rd    = ~cmd_write;
               s_d.addr  = cmd_addr;
               s_d.wdata = cmd_wdata;
               if (cmd_write && freq_hit && resync_on_freq_write) begin
                  s_d.resync = 1'b1;                                // see (RULE11)
               end
            end else if (align_start || s_q.resync) begin
               s_d.resync = 1'b0;
               s_d.pulses = (align_pulses == 4'h0) ? 4'h1 : align_pulses;
               s_d.st     = C_WAIT_RDY;
            end
         end
         C_WAIT_RDY: begin
            if (device_ready) begin
               s_d.st = C_CLR;                                      // see (RULE6)
            end
         end
         C_CLR: begin
            // link-start alignment off, arm bit low
            s_d.wr    = 1'b1;
            s_d.addr  = npps_pkg::OFS_ALIGN;
            s_d.wdata = '0;                                         // see (RULE6)
            s_d.st    = C_ARM;
         end
         C_ARM: begin
            s_d.wr    = 1'b1;
            s_d.addr  = npps_pkg::OFS_ALIGN;
            s_d.wdata = 32'(1) << npps_pkg::ALIGN_ARM_BIT;         // see (RULE4) see (RULE6)
            s_d.cnt   = npps_pkg::SYSREF_LOW_CYC;
            s_d.st    = C_PULSE_LO;
         end
         C_PULSE_LO: begin
            if (s_q.cnt != 8'h00) begin
               s_d.cnt = s_q.cnt - 8'h01;
            end else if (s_q.pulses != 4'h0) begin
               s_d.pulses = s_q.pulses - 4'h1;
               s_d.cnt    = npps_pkg::SYSREF_HIGH_CYC - 8'h01;
               s_d.st     = C_PULSE_HI;
            end else begin
               s_d.st = C_IDLE;
            end
         end
         C_PULSE_HI: begin
            if (s_q.cnt != 8'h00) begin
               s_d.cnt = s_q.cnt - 8'h01;
            end else begin
               s_d.cnt = npps_pkg::SYSREF_LOW_CYC - 8'h01;
               s_d.st  = C_PULSE_LO;
            end
         end
         default: begin
            s_d.st = C_IDLE;
         end
      endcase
      // sysref stays quiet everywhere except the pulse phase
      s_d.sysref = (s_d.st == C_PULSE_HI);                          // see (RULE6)
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '{st: C_IDLE, wr: 1'b0, rd: 1'b0, addr: '0, wdata: '0,
                  sync_n: 1'b0, sysref: 1'b0, cnt: 8'h00, pulses: 4'h0,
                  resync: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign cmd_ready     = (s_q.st == C_IDLE);
   assign align_busy    = (s_q.st != C_IDLE);
   assign rsp_valid     = lnk.reg_rvalid;
   assign rsp_rdata     = lnk.reg_rdata;
   assign lnk.sync_n    = s_q.sync_n;
   assign lnk.sysref    = s_q.sysref;
   assign lnk.reg_wr    = s_q.wr;
   assign lnk.reg_rd    = s_q.rd;
   assign lnk.reg_addr  = s_q.addr;
   assign lnk.reg_wdata = s_q.wdata;

endmodule : npps_ctl

`default_nettype wire

// ### npps_assertions.sv
/* npps_assertions: checks on the link between the two nco_phase_align_control ends.
   Assumes one clk domain, arst_n active low, instantiated by tb. */
`timescale 1ns/1ps
`default_nettype none
module npps_assertions (
   input wire logic                        clk,
   input wire logic                        arst_n,
   input wire logic                        sync_n,
   input wire logic                        sysref,
   input wire logic                        reg_wr,
   input wire logic                        reg_rd,
   input wire logic [npps_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [npps_pkg::DATA_W-1:0] reg_rdata,
   input wire logic                        reg_rvalid
);
   // ----------------------------------------------------------------
   // link checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   rd_answer_a: assert property (reg_rd |=> reg_rvalid)
      else $error("read strobe not answered");
   rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
      else $error("read answer without strobe");
   one_strobe_a: assert property (!(reg_wr && reg_rd))
      else $error("write and read in one cycle");
   pulse_width_a: assert property ($rose(sysref) |-> sysref[*4] ##1 !sysref)
      else $error("sysref pulse width wrong");
   pulse_gap_a: assert property ($fell(sysref) |-> !sysref[*8])
      else $error("sysref gap too short");
   quiet_bus_a: assert property (sysref |-> !reg_wr && !reg_rd)
      else $error("register access during sysref pulse");
   phase_narrow_a: assert property (reg_rd && reg_addr == npps_pkg::OFS_PHASE_A0
      |=> reg_rdata[31:16] == 16'h0000) else $error("phase offset upper bits set");
   unmapped_zero_a: assert property (reg_rd && reg_addr == 12'h100
      |=> reg_rdata == 32'h00000000) else $error("unmapped read not zero");

   cover property ($rose(sysref));
   cover property ($rose(sync_n));
   cover property (reg_wr ##1 reg_rd);
endmodule : npps_assertions
`default_nettype wire

// ### tb.sv
/* tb: both nco_phase_align_control ends joined by npps_if, driven by a bench user.
   Assumes the package, interface, design and checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb;
   // ----------------------------------------------------------------
   // stimulus and checks
   // ----------------------------------------------------------------
   logic        clk = 1'h0, arst_n = 1'h0, lmfc = 1'h0, m64 = 1'h0;
   logic        cv = 1'h0, cw = 1'h0, rxs = 1'h0, go = 1'h0, scm = 1'h0;
   logic        crdy, rv, pip, arm, busy, lsn, fm;
   logic [11:0] ca = 12'h000;
   logic [31:0] cd = 32'h0, r = 32'h3B, q, f, rd, pa, pb;
   logic [15:0] off;
   int          miscompares = 0, n_tests = 0, n_init = 0;
   npps_if lnk ();
   npps_dev i_npps_dev (.clk(clk), .arst_n(arst_n), .lnk(lnk), .link_mode_64b66b(m64),
      .single_channel_mode(scm), .lmfc_boundary(lmfc), .sample_valid(1'h1),
      .preset_pin_sel_a(2'h0), .preset_pin_sel_b(2'h0), .link_sync_n(lsn),
      .phase_init_pulse(pip), .sync_armed(arm), .fractional_mode(fm),
      .nco_phase_a(pa), .nco_phase_b(pb));
   npps_ctl i_npps_ctl (.clk(clk), .arst_n(arst_n), .lnk(lnk), .cmd_valid(cv),
      .cmd_ready(crdy), .cmd_write(cw), .cmd_addr(ca), .cmd_wdata(cd), .rsp_valid(rv),
      .rsp_rdata(rd), .rx_sync_request(rxs), .device_ready(arst_n), .align_start(go),
      .align_pulses(4'h2), .resync_on_freq_write(1'h0), .align_busy(busy));
   npps_assertions ck (.clk(clk), .arst_n(arst_n), .sync_n(lnk.sync_n),
      .sysref(lnk.sysref), .reg_wr(lnk.reg_wr), .reg_rd(lnk.reg_rd),
      .reg_addr(lnk.reg_addr), .reg_rdata(lnk.reg_rdata), .reg_rvalid(lnk.reg_rvalid));
   always #4 clk = ~clk;
   always @(posedge clk) if (pip === 1'h1) n_init <= n_init + 1;
   function automatic logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nx
   function automatic logic [11:0] padr(input logic ch, input logic [1:0] p);
      return 12'h220 + {6'h00, ch, p, 3'h0};
   endfunction : padr
   // expected nco output n samples after phase init
   function automatic logic [31:0] ph(input logic [31:0] w, input logic [15:0] o,
                                      input logic [31:0] n);
      return w * n + {o, 16'h0000};
   endfunction : ph
   task automatic test_done();
      if (miscompares == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : test_done
   task automatic tmo(input int i, input int n);
      if (i >= n) begin
         miscompares++;
         test_done();
      end
   endtask : tmo
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      i = 0;
      @(posedge clk);
      cv <= 1'h1;
      cw <= w;
      ca <= a;
      cd <= d;
      do @(negedge clk); while (crdy !== 1'h1 && ++i < 400);
      @(posedge clk) cv <= 1'h0;
      if (w) repeat (3) @(negedge clk);
      else do @(negedge clk); while (rv !== 1'h1 && ++i < 400);
      q = rd;
      tmo(i, 400);
   endtask : acc
   initial begin
      int k, i, n0;
      logic [1:0] p;
      repeat (20) @(posedge clk);
      arst_n <= 1'h1;
      acc(1'h0, npps_pkg::OFS_FREQ_A0, 32'h0);
      chk(q, 32'hC0000000);
      acc(1'h0, npps_pkg::OFS_ALIGN, 32'h0);
      chk(q, 32'h00000002);
      acc(1'h0, 12'h100, 32'h0);
      chk({31'h0, fm}, 32'h0);
      acc(1'h1, npps_pkg::OFS_RDIV, 32'h00000005);
      chk({31'h0, fm}, 32'h1);
      acc(1'h1, npps_pkg::OFS_RDIV, 32'h0);
      for (k = 0; k < 8; k++) begin
         r = nx(r);
         acc(1'h1, padr(k[2], k[1:0]), r);
         acc(1'h1, padr(k[2], k[1:0]) + 12'h004, r);
         acc(1'h0, padr(k[2], k[1:0]), 32'h0);
         chk(q, r);
         acc(1'h0, padr(k[2], k[1:0]) + 12'h004, 32'h0);
         chk(q, {16'h0000, r[15:0]});
      end
      for (k = 0; k < 2; k++) begin
         @(posedge clk) m64 <= k[0];
         scm <= k[0];
         r = nx(r);
         p = r[1:0];
         f = r;
         off = r[31:16];
         acc(1'h1, padr(1'h0, p), f);
         acc(1'h1, padr(1'h0, p) + 12'h004, {16'h0000, off});
         acc(1'h1, npps_pkg::OFS_PRESET_SEL, {30'h0, p});
         @(posedge clk) rxs <= 1'h1;
         repeat (3) @(negedge clk);
         chk({31'h0, lsn}, {31'h0, k[0]});
         @(posedge clk) rxs <= 1'h0;
         repeat (4) @(posedge clk);
         lmfc <= 1'h1;
         @(posedge clk) lmfc <= 1'h0;
         i = 0;
         do @(negedge clk); while (pip !== 1'h1 && ++i < 20);
         tmo(i, 20);
         chk(pa, ph(f, off, 32'h0));
         if (k[0]) chk(pb, ph(f, off, 32'h0));
         @(negedge clk) chk(pa, ph(f, off, 32'h1));
      end
      n0 = n_init;
      @(posedge clk) go <= 1'h1;
      @(posedge clk) go <= 1'h0;
      i = 0;
      do @(negedge clk); while (busy === 1'h1 && ++i < 400);
      tmo(i, 400);
      chk(n_init - n0, 32'h1);
      chk({31'h0, arm}, 32'h0);
      acc(1'h0, npps_pkg::OFS_ALIGN, 32'h0);
      chk(q, 32'h00000001);
      test_done();
   end
endmodule : tb
`default_nettype wire
